// ==== verif/spi_port_tb.sv ====
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module spi_port_tb;
  import spi_port_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic ctrl_wr = 0, data_wr = 0, data_rd = 0, status_rd = 0, irq_ack = 0, ss_n = 1;
  ctrl_t ctrl = CTRL_RST;
  pin_dir_t dir = '1;
  status_t st;
  logic [7:0] wdata = 8'h00, rdata, ptx = 8'h00, prx, got;
  logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, pmiso;
  logic bsck = 0, bmosi = 0, psel_n = 1, done_q = 0;
  logic sck_w, mosi_w, miso_w;
  int n_errors = 0, checks = 0;
  logic [7:0] exp_q[$];
  int div[8] = '{4, 16, 64, 128, 2, 8, 32, 64};

  // ----------------------------------------
  // clock, pins, instances
  // ----------------------------------------
  always #12.5 i_sys_clk = ~i_sys_clk;
  // pin level from whoever enables its driver
  assign sck_w = sck_oe ? sck_o : bsck;
  assign mosi_w = mosi_oe ? mosi_o : bmosi;
  assign miso_w = miso_oe ? miso_o : pmiso;

  spi_port i_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ctrl_wr(ctrl_wr), .i_ctrl(ctrl),
    .i_pin_dir(dir), .i_data_wr(data_wr), .i_data_wdata(wdata), .i_data_rd(data_rd),
    .i_status_rd(status_rd), .i_irq_ack(irq_ack), .o_rdata(rdata), .o_status(st), .o_irq(irq),
    .i_sck_in(sck_w), .o_sck_out(sck_o), .o_sck_oe(sck_oe), .i_mosi_in(mosi_w), .o_mosi_out(mosi_o),
    .o_mosi_oe(mosi_oe), .i_miso_in(miso_w), .o_miso_out(miso_o), .o_miso_oe(miso_oe), .i_ss_n(ss_n));

  spi_slave_model i_far (.i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n(psel_n), .i_clock_idle_level(ctrl.clock_idle_level),
    .i_sample_edge_select(ctrl.sample_edge_select), .i_tx(ptx), .o_miso(pmiso), .o_rx(prx));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction : rev

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : tick

  // one-cycle strobe, then one idle cycle so strobes never merge
  task automatic pulse(input int k);
    case (k)
      0: ctrl_wr <= 1'b1;
      1: data_wr <= 1'b1;
      2: data_rd <= 1'b1;
      3: status_rd <= 1'b1;
      default: irq_ack <= 1'b1;
    endcase
    tick(1);
    {ctrl_wr, data_wr, data_rd, status_rd, irq_ack} <= 5'h00;
    tick(1);
  endtask : pulse

  // bench as external master, 3-cycle phases, idle low, sample leading
  task automatic sbyte(input logic [7:0] d, input int nb, output logic [7:0] g);
    g = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      bmosi <= d[i];
      tick(3);
      g[i] = miso_w;
      bsck <= 1'b1;
      tick(3);
      bsck <= 1'b0;
    end
    tick(3);
  endtask : sbyte

  task automatic master_xfer(input int r);
    ctrl_t c;
    logic [7:0] d, p;
    int n;
    c = '0;
    {c.transfer_irq_enable, c.bit_order_select, c.clock_idle_level, c.sample_edge_select} = 4'($urandom);
    {c.serial_port_enable, c.master_select} = 2'h3;
    {c.rate_doubler, c.rate_select_hi, c.rate_select_lo} = 3'(r);
    d = 8'($urandom);
    p = 8'($urandom);
    ctrl <= c;
    wdata <= d;
    ptx <= p;
    pulse(0);
    chk("miso_oe", 0, miso_oe);
    chk("sck_oe", 1, sck_oe);
    psel_n <= 1'b0;
    exp_q.push_back(c.bit_order_select ? rev(p) : p);
    data_wr <= 1'b1;
    n = 0;
    // a second write mid-shift must be refused and flagged
    while (st.transfer_done_flag !== 1'b1 && n < 1100) begin
      tick(1);
      n++;
      data_wr <= (n == 3);
      if (n == 3) wdata <= ~d;
    end
    chk("latency", 16'(8 * div[r] + 2), 16'(n));
    chk("write_collision_flag", 1, st.write_collision_flag);
    chk("irq", c.transfer_irq_enable, irq);
    chk("sck_idle", c.clock_idle_level, sck_o);
    chk("far_rx", c.bit_order_select ? rev(d) : d, prx);
    psel_n <= 1'b1;
    if (r[0]) begin
      pulse(4);
      chk("done_ack", 0, st.transfer_done_flag);
      chk("write_collision_flag_kept", 1, st.write_collision_flag);
    end
    pulse(3);
    pulse(2);
    chk("flags", 0, {st.transfer_done_flag, st.write_collision_flag});
    chk("irq_off", 0, irq);
    chk("rdata_kept", c.bit_order_select ? rev(p) : p, rdata);
    $display("test master rate %0d done", r);
  endtask : master_xfer

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // result watcher: each rising done flag retires the oldest expected byte
  always @(posedge i_sys_clk) begin
    done_q <= st.transfer_done_flag;
    if (st.transfer_done_flag === 1'b1 && done_q !== 1'b1 && exp_q.size() > 0) begin
      chk("rdata", exp_q.pop_front(), rdata);
    end
  end

  // hang guard, well past the slowest rate sweep
  initial begin
    #(40000 * 25);
    n_errors++;
    finish_test();
  end

  initial begin
    void'($urandom(85961));
    tick(2);
    i_reset <= 1'b0;
    tick(1);
    for (int r = 0; r < 8; r++) master_xfer(r);
    // select pulled low by another master while ss pin is an input
    dir.ss <= 1'b0;
    ss_n <= 1'b0;
    tick(3);
    chk("fault_master_select", 0, st.master_select);
    chk("fault_done", 1, st.transfer_done_flag);
    ss_n <= 1'b1;
    dir <= '1;
    pulse(4);
    $display("test select fault done");
    // slave: preload while deselected, two bytes, then a cut byte
    ctrl <= '{serial_port_enable: 1'b1, default: 1'b0};
    pulse(0);
    wdata <= 8'ha6;
    pulse(1);
    chk("miso_off", 0, miso_oe);
    chk("in_only", 0, {sck_oe, mosi_oe});
    ss_n <= 1'b0;
    tick(2);
    chk("miso_on", 1, miso_oe);
    exp_q.push_back(8'h3c);
    sbyte(8'h3c, 8, got);
    chk("slave_tx", 8'ha6, got);
    chk("slave_done", 1, st.transfer_done_flag);
    pulse(4);
    wdata <= 8'h51;
    pulse(1);
    exp_q.push_back(8'hc9);
    sbyte(8'hc9, 8, got);
    chk("slave_tx2", 8'h51, got);
    pulse(4);
    sbyte(8'hff, 3, got);
    ss_n <= 1'b1;
    tick(3);
    chk("cut_hold", 8'hc9, rdata);
    chk("cut_done", 0, st.transfer_done_flag);
    // a fresh select must count a whole byte from bit zero again
    ss_n <= 1'b0;
    tick(2);
    exp_q.push_back(8'h5a);
    sbyte(8'h5a, 8, got);
    chk("resync_done", 1, st.transfer_done_flag);
    ss_n <= 1'b1;
    tick(2);
    $display("test slave done");
    finish_test();
  end
endmodule : spi_port_tb

// ==== verif/spi_slave_model.sv ====
// behavioural far-side slave used while the port is master
`timescale 1ns/1ps
module spi_slave_model (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_sel_n,
  input wire logic i_clock_idle_level,
  input wire logic i_sample_edge_select,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  logic [7:0] sh = 8'h00;
  // load on select; always msb first, the bench mirrors for lsb first
  always @(negedge i_sel_n) begin
    sh = i_tx;
    o_rx = 8'h00;
  end
  // act just after each clock edge; shifting right after the sample edge
  // gives the master no more hold time than a real slave would
  always @(i_sck) begin
    #1;
    if (!i_sel_n && ((i_sck != i_clock_idle_level) ^ i_sample_edge_select)) begin
      o_rx = {o_rx[6:0], i_mosi};
      sh = {sh[6:0], 1'b0};
    end
  end
  // released line shows the inverse so stale data cannot pass
  assign o_miso = i_sel_n ? ~sh[7] : sh[7];
endmodule : spi_slave_model

// ==== verilog/spi_port.sv ====
// serial peripheral port, master or slave, byte oriented
//
// Contract
// - master data write starts the clock and shifts eight bits out
// - after a master byte the clock stops and done flag sets
// - done flag with irq enable raises the interrupt request
// - next byte by new write or packet end by select; last byte stays readable
// - slave with select high idles, miso off, data writable, no shifting
// - slave completing a byte sets done flag and may request interrupt
// - slave may load next transmit byte before reading received byte
// - transmit single buffered, writes refused during a shift cycle
// - receive double buffered, held until next byte completes, then overwritten
// - slave clock phases must exceed two system cycles each
// - master forces miso input; slave forces mosi, sck, ss input
// - mosi carries master to slave, miso slave to master, simultaneously
// - both lsb first and msb first shifting supported
// - seven distinct master clock rates, fastest divides by two
// - rate bits and doubler choose divide 4,16,64,128 or 2,8,32,64
// - idle level sets sck rest state, phase picks sample edge
// - select input low in master mode drops to slave and sets done
// - data write during a transfer sets the collision flag
`timescale 1ns/1ps
module spi_port
  import spi_port_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ctrl_wr,
  input wire spi_port_pkg::ctrl_t i_ctrl,
  input wire spi_port_pkg::pin_dir_t i_pin_dir,
  input wire logic i_data_wr,
  input wire logic [spi_port_pkg::DATA_W-1:0] i_data_wdata,
  input wire logic i_data_rd,
  input wire logic i_status_rd,
  input wire logic i_irq_ack,
  output logic [spi_port_pkg::DATA_W-1:0] o_rdata,
  output spi_port_pkg::status_t o_status,
  output logic o_irq,
  input wire logic i_sck_in,
  output logic o_sck_out,
  output logic o_sck_oe,
  input wire logic i_mosi_in,
  output logic o_mosi_out,
  output logic o_mosi_oe,
  input wire logic i_miso_in,
  output logic o_miso_out,
  output logic o_miso_oe,
  input wire logic i_ss_n
);
  import spi_port_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic tx_bit(input logic [DATA_W-1:0] sh, input logic lsb);
    tx_bit = lsb ? sh[0] : sh[DATA_W-1];
  endfunction : tx_bit

  function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] sh, input logic b, input logic lsb);
    shift_in = lsb ? {b, sh[DATA_W-1:1]} : {sh[DATA_W-2:0], b};
  endfunction : shift_in

  function automatic logic [HALF_W-1:0] rate_half(input logic dbl, input logic hi, input logic lo);
    case ({dbl, hi, lo})
      3'h0: rate_half = HALF_DIV4;
      3'h1: rate_half = HALF_DIV16;
      3'h2: rate_half = HALF_DIV64;
      3'h3: rate_half = HALF_DIV128;
      3'h4: rate_half = HALF_DIV2;
      3'h5: rate_half = HALF_DIV8;
      3'h6: rate_half = HALF_DIV32;
      default: rate_half = HALF_DIV64;
    endcase
  endfunction : rate_half

  typedef enum logic {ST_IDLE, ST_SHIFT} mstate_t;

  ctrl_t ctrl_ff, nxt_ctrl;
  mstate_t mst_ff, nxt_mst;
  logic [DATA_W-1:0] sh_ff, nxt_sh, rx_ff, nxt_rx;
  logic [BIT_CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
  logic [EDGE_CNT_W-1:0] edge_cnt_ff, nxt_edge_cnt;
  logic out_ff, nxt_out, sck_ph_ff, nxt_sck_ph, sck_prev_ff, ss_prev_ff;
  logic done_ff, nxt_done, write_collision_flag_ff, nxt_write_collision_flag, arm_ff, nxt_arm;
  logic tick, is_master, slave_sel, busy, edge_ev, edge_lead, sample, setup;
  logic rx_in, byte_done, ss_fault, wr_ok, idle_load, flag_clr;

  // ---------------------------------------------------------------
  // master rate divider
  // ---------------------------------------------------------------
  spi_rate_div #(.HALF_W(HALF_W)) u_div (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_run(mst_ff == ST_SHIFT),
    .i_half(rate_half(ctrl_ff.rate_doubler, ctrl_ff.rate_select_hi, ctrl_ff.rate_select_lo)),
    .o_tick(tick)
  );

  // ---------------------------------------------------------------
  // edge decode shared by master and slave
  // ---------------------------------------------------------------
  always_comb begin
    is_master = ctrl_ff.serial_port_enable && ctrl_ff.master_select;
    slave_sel = ctrl_ff.serial_port_enable && !ctrl_ff.master_select && !i_ss_n;
    // select input pulled low while master means another master took the bus
    ss_fault = is_master && !i_pin_dir.ss && !i_ss_n;
    busy = (mst_ff == ST_SHIFT) || (slave_sel && bit_cnt_ff != '0);
    if (is_master) begin
      edge_ev = (mst_ff == ST_SHIFT) && tick && !ss_fault;
      edge_lead = !edge_cnt_ff[0];
      rx_in = i_miso_in;
    end else begin
      // slave sck is oversampled, so each phase must outlast two cycles
      edge_ev = slave_sel && (i_sck_in != sck_prev_ff);
      edge_lead = (i_sck_in != ctrl_ff.clock_idle_level);
      rx_in = i_mosi_in;
    end
    sample = edge_ev && (edge_lead ^ ctrl_ff.sample_edge_select);
    setup = edge_ev && !(edge_lead ^ ctrl_ff.sample_edge_select);
    byte_done = is_master ? (edge_ev && edge_cnt_ff == LAST_EDGE)
                          : (sample && bit_cnt_ff == LAST_BIT);
    wr_ok = i_data_wr && !busy && !sample;
    idle_load = !busy;
  end

  // ---------------------------------------------------------------
  // shift datapath, bit counters and master sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_mst = mst_ff;
    nxt_sh = sh_ff;
    nxt_rx = rx_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_edge_cnt = edge_cnt_ff;
    nxt_out = out_ff;
    nxt_sck_ph = sck_ph_ff;
    if (i_ctrl_wr) begin
      nxt_ctrl = i_ctrl;
    end
    if (ss_fault) begin
      nxt_ctrl.master_select = 1'b0;
    end
    if (sample) begin
      nxt_sh = shift_in(sh_ff, rx_in, ctrl_ff.bit_order_select);
      nxt_bit_cnt = bit_cnt_ff + BIT_CNT_W'(1);
    end else if (wr_ok) begin
      nxt_sh = i_data_wdata;
    end
    if (byte_done) begin
      nxt_rx = nxt_sh;
    end
    // output bit follows the shifter while idle and on setup edges
    if (setup || idle_load) begin
      nxt_out = tx_bit(nxt_sh, ctrl_ff.bit_order_select);
    end
    case (mst_ff)
      ST_IDLE: begin
        nxt_sck_ph = 1'b0;
        nxt_edge_cnt = '0;
        if (is_master && wr_ok && !ss_fault) begin
          nxt_mst = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (ss_fault || !is_master) begin
          nxt_mst = ST_IDLE;
          nxt_bit_cnt = '0;
        end else if (edge_ev) begin
          nxt_sck_ph = !sck_ph_ff;
          nxt_edge_cnt = edge_cnt_ff + EDGE_CNT_W'(1);
          if (byte_done) begin
            nxt_mst = ST_IDLE;
          end
        end
      end
      default: nxt_mst = ST_IDLE;
    endcase
    // select high drops a partial slave byte at once
    if (!is_master && !slave_sel) begin
      nxt_bit_cnt = '0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_ff <= CTRL_RST;
      mst_ff <= ST_IDLE;
      sh_ff <= DATA_RST;
      rx_ff <= DATA_RST;
      bit_cnt_ff <= '0;
      edge_cnt_ff <= '0;
      out_ff <= 1'b0;
      sck_ph_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
      ss_prev_ff <= 1'b1;
    end else begin
      ctrl_ff <= nxt_ctrl;
      mst_ff <= nxt_mst;
      sh_ff <= nxt_sh;
      rx_ff <= nxt_rx;
      bit_cnt_ff <= nxt_bit_cnt;
      edge_cnt_ff <= nxt_edge_cnt;
      out_ff <= nxt_out;
      sck_ph_ff <= nxt_sck_ph;
      sck_prev_ff <= i_sck_in;
      ss_prev_ff <= i_ss_n;
    end
  end

  // ---------------------------------------------------------------
  // status flags; a set in the clearing cycle wins
  // ---------------------------------------------------------------
  always_comb begin
    flag_clr = arm_ff && (i_data_rd || i_data_wr);
    nxt_arm = arm_ff;
    if (i_status_rd && (done_ff || write_collision_flag_ff)) begin
      nxt_arm = 1'b1;
    end else if (flag_clr) begin
      nxt_arm = 1'b0;
    end
    nxt_done = byte_done || ss_fault || (done_ff && !flag_clr && !i_irq_ack);
    nxt_write_collision_flag = (i_data_wr && (busy || sample)) || (write_collision_flag_ff && !flag_clr);
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      done_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      arm_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
      write_collision_flag_ff <= nxt_write_collision_flag;
      arm_ff <= nxt_arm;
    end
  end

  // ---------------------------------------------------------------
  // outputs and pin direction overrides
  // ---------------------------------------------------------------
  always_comb begin
    o_rdata = rx_ff;
    o_status.transfer_done_flag = done_ff;
    o_status.write_collision_flag = write_collision_flag_ff;
    o_status.master_select = ctrl_ff.master_select;
    o_irq = done_ff && ctrl_ff.transfer_irq_enable;
    o_sck_out = ctrl_ff.clock_idle_level ^ sck_ph_ff;
    o_mosi_out = out_ff;
    o_miso_out = out_ff;
    // a disabled port leaves every pin undriven
    o_sck_oe = is_master && i_pin_dir.sck;
    o_mosi_oe = is_master && i_pin_dir.mosi;
    o_miso_oe = slave_sel && i_pin_dir.miso;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence wr_in_flight;
    busy && i_data_wr;
  endsequence

  sequence master_launch;
    mst_ff == ST_IDLE && is_master && i_data_wr && !ss_fault;
  endsequence

  irq_raise_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    byte_done && ctrl_ff.transfer_irq_enable && !i_ctrl_wr |=> o_irq)
    else $error("done with irq enable gave no interrupt");

  master_start_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    master_launch |=> mst_ff == ST_SHIFT && edge_cnt_ff == '0)
    else $error("master write did not start a transfer");

  master_done_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    is_master && byte_done |=> mst_ff == ST_IDLE && done_ff && sck_ph_ff == 1'b0)
    else $error("master byte end did not stop and flag");

  write_collision_flag_set_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_in_flight |=> write_collision_flag_ff)
    else $error("collision flag not set");

  tx_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_in_flight and !sample |=> sh_ff == $past(sh_ff))
    else $error("busy write altered shifter");

  rx_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !byte_done |=> rx_ff == $past(rx_ff))
    else $error("receive buffer changed without a byte");

  miso_off_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ss_n || is_master) |-> !o_miso_oe)
    else $error("miso driven while deselected or master");

  slave_pins_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !ctrl_ff.master_select |-> !o_mosi_oe && !o_sck_oe)
    else $error("slave drove mosi or sck");

  ss_fault_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    ss_fault |=> !ctrl_ff.master_select && done_ff ##1 mst_ff == ST_IDLE)
    else $error("select fault did not demote master");

  ss_drop_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !ctrl_ff.master_select && !ss_prev_ff && i_ss_n |=> bit_cnt_ff == '0)
    else $error("partial byte kept after select rose");

  flag_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    flag_clr && !byte_done && !ss_fault |=> !done_ff)
    else $error("done flag not cleared by access");

endmodule : spi_port

// ==== verilog/spi_port_pkg.sv ====
// shared types and constants for the serial peripheral port
package spi_port_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam int EDGE_CNT_W = 4;
  localparam int HALF_W = 7;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [EDGE_CNT_W-1:0] LAST_EDGE = 4'hf;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 40;
  localparam int SLAVE_MIN_PHASE_CYC = 2;

  // ---------------------------------------------------------------
  // half serial clock period in system cycles, per rate setting
  // ---------------------------------------------------------------
  localparam logic [HALF_W-1:0] HALF_DIV4 = 7'h02;
  localparam logic [HALF_W-1:0] HALF_DIV16 = 7'h08;
  localparam logic [HALF_W-1:0] HALF_DIV64 = 7'h20;
  localparam logic [HALF_W-1:0] HALF_DIV128 = 7'h40;
  localparam logic [HALF_W-1:0] HALF_DIV2 = 7'h01;
  localparam logic [HALF_W-1:0] HALF_DIV8 = 7'h04;
  localparam logic [HALF_W-1:0] HALF_DIV32 = 7'h10;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic transfer_irq_enable;
    logic serial_port_enable;
    logic bit_order_select;
    logic master_select;
    logic clock_idle_level;
    logic sample_edge_select;
    logic rate_select_hi;
    logic rate_select_lo;
    logic rate_doubler;
  } ctrl_t;

  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic master_select;
  } status_t;

  // user data direction of the four pins (1 = output)
  typedef struct packed {
    logic mosi;
    logic miso;
    logic sck;
    logic ss;
  } pin_dir_t;

  localparam ctrl_t CTRL_RST = '0;

endpackage : spi_port_pkg

// ==== verilog/spi_rate_div.sv ====
// serial clock rate divider producing half period enable pulses
`timescale 1ns/1ps
module spi_rate_div #(
  parameter int HALF_W = 7
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [HALF_W-1:0] i_half,
  output logic o_tick
);

  logic [HALF_W-1:0] cnt_ff;
  logic [HALF_W-1:0] nxt_cnt;

  // ---------------------------------------------------------------
  // counter, restarted while idle so the first half period is whole
  // ---------------------------------------------------------------
  always_comb begin
    o_tick = i_run && (cnt_ff == i_half - HALF_W'(1));
    if (!i_run || o_tick) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + HALF_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // no two ticks in a row once the programmed half period exceeds one
  tick_space_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_tick && i_run && $stable(i_half) && i_half > HALF_W'(1) |=> !o_tick)
    else $error("divider ticked twice in a row");

endmodule : spi_rate_div
